// File: src/output_signal_allocator.sv
// Output signal allocator: Avalon-MM registers, routing and registered outputs
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module output_signal_allocator
  import out_alloc_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Status functions from the drive
  input  wire logic [NUM_FUNCS-1:0] func_level,
  input  wire logic [NUM_FUNCS-1:0] func_valid,
  // Output circuits of io_connector
  output logic      [NUM_OUTS-1:0]  out_circuit
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] regs_q [NUM_RW_REGS];
  logic [31:0] readdata_q;
  logic        ack_q;
  logic        wait_q;
  logic [NUM_OUTS-1:0] out_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire         req_w     = read | write;
  wire         wr_fire   = write & ack_q;
  wire         rd_launch = req_w & ~ack_q;
  wire [15:0]  be_mask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire         in_rw     = (address < ADDR_W'(NUM_RW_REGS));

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = UNMAPPED_RD;
    if (in_rw) begin
      rd_mux = {16'h0000, regs_q[address]};
    end else if (address == OFF_OUT_STATE) begin
      rd_mux = {27'h000_0000, out_q};
    end else if (address == OFF_FUNC_STATE) begin
      rd_mux = {func_valid, func_level};
    end
  end

  // Answer one cycle after the request is seen, then drop for one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q      <= 1'b0;
      wait_q     <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q  <= rd_launch;
      wait_q <= ~rd_launch;
      if (rd_launch && read) begin
        readdata_q <= rd_mux;
      end
    end
  end

  assign waitrequest = wait_q;
  assign readdata    = readdata_q;

  genvar r;
  generate
    for (r = 0; r < NUM_RW_REGS; r++) begin : g_reg
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          regs_q[r] <= (r >= 7) ? RST_POLARITY : RST_SEL;
        end else if (wr_fire && address == ADDR_W'(r)) begin
          regs_q[r] <= (regs_q[r] & ~be_mask) | (writedata[15:0] & be_mask);
        end
      end
    end
  endgenerate

  // ****************************************
  // Selector gathering
  // ****************************************
  logic [NUM_FUNCS*SEL_W-1:0] sel_flat;

  assign sel_flat[F_POS_COMPLETE*SEL_W +: SEL_W] = regs_q[OFF_ROUTE_A][3:0];
  assign sel_flat[F_SPEED_MATCH*SEL_W  +: SEL_W] = regs_q[OFF_ROUTE_A][7:4];
  assign sel_flat[F_ROTATING*SEL_W     +: SEL_W] = regs_q[OFF_ROUTE_A][11:8];
  assign sel_flat[F_SERVO_READY*SEL_W  +: SEL_W] = regs_q[OFF_ROUTE_A][15:12];
  assign sel_flat[F_TORQUE_LIM*SEL_W   +: SEL_W] = regs_q[OFF_ROUTE_B][3:0];
  assign sel_flat[F_SPEED_LIM*SEL_W    +: SEL_W] = regs_q[OFF_ROUTE_B][7:4];
  assign sel_flat[F_BRAKE_REL*SEL_W    +: SEL_W] = regs_q[OFF_ROUTE_B][11:8];
  assign sel_flat[F_ALERT*SEL_W        +: SEL_W] = regs_q[OFF_ROUTE_B][15:12];
  assign sel_flat[F_PROXIMITY*SEL_W    +: SEL_W] = regs_q[OFF_PROXIMITY][3:0];
  assign sel_flat[F_MAINT_DUE*SEL_W    +: SEL_W] = regs_q[OFF_MAINT][11:8];
  assign sel_flat[F_DYN_BRAKE*SEL_W    +: SEL_W] = regs_q[OFF_BRAKE_REQ][7:4];
  assign sel_flat[F_ZONE_1*SEL_W       +: SEL_W] = regs_q[OFF_ZONE][3:0];
  assign sel_flat[F_ZONE_2*SEL_W       +: SEL_W] = regs_q[OFF_ZONE][7:4];
  assign sel_flat[F_ZONE_3*SEL_W       +: SEL_W] = regs_q[OFF_ZONE][11:8];
  assign sel_flat[F_ZONE_4*SEL_W       +: SEL_W] = regs_q[OFF_ZONE][15:12];
  assign sel_flat[F_ZONE_INDEX*SEL_W   +: SEL_W] = regs_q[OFF_ZONE_N][3:0];

  // ****************************************
  // Polarity gathering
  // ****************************************
  logic [NUM_OUTS-1:0] invert;
  assign invert = {regs_q[OFF_POLARITY_B][0],
                   regs_q[OFF_POLARITY_A][12], regs_q[OFF_POLARITY_A][8],
                   regs_q[OFF_POLARITY_A][4],  regs_q[OFF_POLARITY_A][0]};

  // ****************************************
  // Routing and output register
  // ****************************************
  logic [NUM_OUTS-1:0] routed;

  out_route_core #(
    .FUNCS (NUM_FUNCS),
    .OUTS  (NUM_OUTS)
  ) u_core (
    .func_level (func_level),
    .func_valid (func_valid),
    .func_sel   (sel_flat),
    .invert     (invert),
    .routed     (routed)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= routed;
    end
  end

  assign out_circuit = out_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  function automatic logic expect_out(input int o, input logic [NUM_FUNCS-1:0] lv,
                                      input logic [NUM_FUNCS-1:0] vd,
                                      input logic [NUM_FUNCS*SEL_W-1:0] sl,
                                      input logic [NUM_OUTS-1:0] inv);
    logic acc;
    acc = 1'b0;
    for (int f = 0; f < NUM_FUNCS; f++) begin
      if (vd[f] && lv[f] && sl[f*SEL_W +: SEL_W] == SEL_W'(o + 1)) begin
        acc = 1'b1;
      end
    end
    return acc ^ inv[o];
  endfunction

  route_out0_a: assert property (
      out_circuit[0] == expect_out(0, $past(func_level), $past(func_valid),
                                   $past(sel_flat), $past(invert)))
    else $error("circuit 1 mismatch");
  route_out4_a: assert property (
      out_circuit[4] == expect_out(4, $past(func_level), $past(func_valid),
                                   $past(sel_flat), $past(invert)))
    else $error("circuit 5 mismatch");
  sel_zero_a: assert property (
      (sel_flat[3:0] == SEL_NONE && invert == '0 && (func_level & func_valid) == 16'h0001)
      |=> out_circuit == '0)
    else $error("disconnected function drives output");
  invalid_off_a: assert property (
      (func_valid == '0 && invert == '0) |=> out_circuit == '0)
    else $error("unevaluated function drives output");
  invert_all_a: assert property (
      (func_valid == '0 && invert == '1) |=> out_circuit == '1)
    else $error("polarity not applied");
  pol_write_a: assert property (
      (wr_fire && address == OFF_POLARITY_B && byteenable[0])
      |=> invert[4] == $past(writedata[0]))
    else $error("circuit 5 polarity not stored");
  route_write_a: assert property (
      (wr_fire && address == OFF_ROUTE_A && byteenable[0])
      |=> sel_flat[3:0] == $past(writedata[3:0]))
    else $error("selector not stored");
  bus_answer_a: assert property (
      (req_w && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  reset_out_a: assert property (
      @(posedge ref_clk) disable iff (1'b0) $fell(rst) |-> out_circuit == '0)
    else $error("outputs active after reset");

  read_cov_c:  cover property (read && !waitrequest);
  write_cov_c: cover property (write && !waitrequest);
  or_cov_c:    cover property ($countones(func_level & func_valid) > 1 && out_circuit != '0);
  inv_cov_c:   cover property (invert != '0 && out_circuit != '0);

endmodule // output_signal_allocator

// File: common/out_alloc_pkg.sv
// Package: constants, register map and carrier types of the output signal allocator
package out_alloc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_FUNCS   = 16;
  localparam int NUM_OUTS    = 5;
  localparam int SEL_W       = 4;
  localparam int ADDR_W      = 4;

  // ****************************************
  // Register word offsets (one address step per register)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_ROUTE_A     = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ROUTE_B     = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PROXIMITY   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_MAINT       = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_BRAKE_REQ   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ZONE        = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_ZONE_N      = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_POLARITY_A  = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_POLARITY_B  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_OUT_STATE   = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_FUNC_STATE  = 4'hA;
  localparam int                NUM_RW_REGS     = 9;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_SEL      = 16'h0000;
  localparam logic [15:0] RST_POLARITY = 16'h0000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // ****************************************
  // Selector codes
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_NONE     = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RESERVED = 4'h6;

  // ****************************************
  // Function indices on the status vector
  // ****************************************
  localparam int F_POS_COMPLETE = 0;
  localparam int F_SPEED_MATCH  = 1;
  localparam int F_ROTATING     = 2;
  localparam int F_SERVO_READY  = 3;
  localparam int F_TORQUE_LIM   = 4;
  localparam int F_SPEED_LIM    = 5;
  localparam int F_BRAKE_REL    = 6;
  localparam int F_ALERT        = 7;
  localparam int F_PROXIMITY    = 8;
  localparam int F_MAINT_DUE    = 9;
  localparam int F_DYN_BRAKE    = 10;
  localparam int F_ZONE_1       = 11;
  localparam int F_ZONE_2       = 12;
  localparam int F_ZONE_3       = 13;
  localparam int F_ZONE_4       = 14;
  localparam int F_ZONE_INDEX   = 15;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } bus_req_type;

  typedef struct packed {
    logic [NUM_FUNCS-1:0] level;
    logic [NUM_FUNCS-1:0] valid;
  } status_type;

endpackage

// File: src/out_route_core.sv
// Combinational routing of status functions onto output circuits
`timescale 1ns/10ps
module out_route_core
  import out_alloc_pkg::*;
#(
  parameter int FUNCS = NUM_FUNCS,
  parameter int OUTS  = NUM_OUTS
) (
  // Status in
  input  wire logic [FUNCS-1:0]       func_level,
  input  wire logic [FUNCS-1:0]       func_valid,
  // Selectors and polarity
  input  wire logic [FUNCS*SEL_W-1:0] func_sel,
  input  wire logic [OUTS-1:0]        invert,
  // Routed result
  output logic      [OUTS-1:0]        routed
);

  // A 4-bit selector can name at most fifteen circuits
  if (FUNCS < 1 || OUTS < 1 || OUTS > 15) begin : g_bad_size
    $error("out_route_core: FUNCS must be at least 1 and OUTS 1 to 15");
  end

  logic [FUNCS-1:0] live;

  assign live = func_level & func_valid;

  genvar o;
  generate
    for (o = 0; o < OUTS; o++) begin : g_out
      logic [FUNCS-1:0] hit;
      genvar f;
      for (f = 0; f < FUNCS; f++) begin : g_func
        assign hit[f] = live[f] &&
          (func_sel[f*SEL_W +: SEL_W] == SEL_W'(o + 1));
      end
      assign routed[o] = (|hit) ^ invert[o];
    end
  endgenerate

endmodule // out_route_core

// File: verif/contact_load.sv
// Model of the external load wired to the five output circuits
`timescale 1ns/10ps
module contact_load
  import out_alloc_pkg::*;
(
  // Output circuits at io_connector
  input  wire logic [NUM_OUTS-1:0] out_circuit,
  // Contact state seen by the host side
  output logic      [NUM_OUTS-1:0] contact_closed
);
  assign contact_closed = out_circuit;
endmodule // contact_load

// File: verif/output_signal_allocator_tb_top.sv
// Self-checking testbench of the output signal allocator
`timescale 1ns/10ps
module output_signal_allocator_tb_top
  import out_alloc_pkg::*;
;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 read = 1'b0;
  logic                 write = 1'b0;
  logic [ADDR_W-1:0]    address = 4'h0;
  logic [31:0]          writedata = 32'h0000_0000;
  logic [3:0]           byteenable = 4'hF;
  logic [31:0]          readdata;
  logic [31:0]          rd;
  logic                 waitrequest;
  logic [NUM_FUNCS-1:0] func_level = 16'hFFFF;
  logic [NUM_FUNCS-1:0] func_valid = 16'hFFFF;
  logic [NUM_OUTS-1:0]  out_circuit;
  logic [NUM_OUTS-1:0]  contact_closed;
  int                   n_errors = 0;
  int                   n_checks = 0;
  int                   cycles = 0;

  output_signal_allocator u_output_signal_allocator (.ref_clk(ref_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .func_level(func_level), .func_valid(func_valid), .out_circuit(out_circuit));
  contact_load u_contact_load (.out_circuit(out_circuit), .contact_closed(contact_closed));

  always #5 ref_clk = ~ref_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      report_and_stop;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    if (i >= 50) n_errors++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task drive(input logic [NUM_FUNCS-1:0] lv, input logic [NUM_FUNCS-1:0] vd);
    @(posedge ref_clk);
    func_level <= lv;
    func_valid <= vd;
  endtask

  task out_is(input logic [NUM_OUTS-1:0] e);
    repeat (3) @(posedge ref_clk);
    #1 chk("contact_closed", 32'(e), 32'(contact_closed));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset_values;
    int i;
    for (i = 0; i < NUM_RW_REGS; i++) begin
      bus(1'b0, i[ADDR_W-1:0], 32'h0000_0000);
      chk("register reset value", 32'h0000_0000, rd);
    end
  endtask

  task t_place;
    int r, d, k;
    logic [ADDR_W-1:0] regs [3];
    int f0 [3];
    regs = '{OFF_ROUTE_A, OFF_ROUTE_B, OFF_ZONE};
    f0 = '{F_POS_COMPLETE, F_TORQUE_LIM, F_ZONE_1};
    // Brake release is never inverted here; code 6 is never written
    for (r = 0; r < 3; r++) begin
      for (d = 0; d < 4; d++) begin
        for (k = 0; k < 6; k++) begin
          bus(1'b1, regs[r], 32'(k) << (4 * d));
          drive(16'h0001 << (f0[r] + d), 16'hFFFF);
          out_is((k == 0) ? 5'h00 : 5'h01 << (k - 1));
          drive(~(16'h0001 << (f0[r] + d)), 16'hFFFF);
          out_is(5'h00);
        end
      end
      bus(1'b1, regs[r], 32'h0000_0000);
    end
  endtask

  // Single-digit selectors outside the two route registers and the zone register
  task t_single;
    logic [ADDR_W-1:0] regs [4];
    logic [15:0] val [4];
    int fn [4];
    int r;
    regs = '{OFF_PROXIMITY, OFF_MAINT, OFF_BRAKE_REQ, OFF_ZONE_N};
    val = '{16'h0001, 16'h0200, 16'h0030, 16'h0004};
    fn = '{F_PROXIMITY, F_MAINT_DUE, F_DYN_BRAKE, F_ZONE_INDEX};
    for (r = 0; r < 4; r++) begin
      bus(1'b1, regs[r], 32'(val[r]));
      drive(16'h0001 << fn[r], 16'hFFFF);
      out_is(5'h01 << r);
      bus(1'b1, regs[r], 32'h0000_0000);
    end
  endtask

  task t_or_and_valid;
    int i;
    bus(1'b1, OFF_ROUTE_A, 32'h0000_0022);
    for (i = 0; i < 4; i++) begin
      drive(16'(i), 16'hFFFF);
      out_is((i == 0) ? 5'h00 : 5'h02);
    end
    drive(16'h0003, 16'h0000);
    out_is(5'h00);
    drive(16'h0001, 16'hFFFE);
    out_is(5'h00);
    drive(16'h0003, 16'h0002);
    out_is(5'h02);
  endtask

  task t_polarity;
    int d;
    bus(1'b1, OFF_ROUTE_A, 32'h0000_0000);
    drive(16'h0000, 16'hFFFF);
    for (d = 0; d < 4; d++) begin
      bus(1'b1, OFF_POLARITY_A, 32'h0000_0001 << (4 * d));
      out_is(5'h01 << d);
    end
    bus(1'b1, OFF_POLARITY_A, 32'h0000_0000);
    bus(1'b1, OFF_POLARITY_B, 32'h0000_0001);
    out_is(5'h10);
    bus(1'b1, OFF_ROUTE_A, 32'h0000_0005);
    drive(16'h0001, 16'hFFFF);
    out_is(5'h00);
    bus(1'b1, OFF_POLARITY_A, 32'h0000_1111);
    out_is(5'h0F);
    drive(16'h0001, 16'h0000);
    out_is(5'h1F);
    drive(16'h0001, 16'hFFFF);
  endtask

  task t_refused;
    bus(1'b1, OFF_OUT_STATE, 32'h0000_0010);
    bus(1'b0, OFF_OUT_STATE, 32'h0000_0000);
    chk("output state", 32'h0000_000F, rd);
    bus(1'b1, 4'hC, 32'h0000_FFFF);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk("unmapped read", UNMAPPED_RD, rd);
    bus(1'b0, OFF_FUNC_STATE, 32'h0000_0000);
    chk("function state", 32'hFFFF_0001, rd);
    byteenable <= 4'h1;
    bus(1'b1, OFF_ROUTE_A, 32'h0000_3333);
    byteenable <= 4'h2;
    bus(1'b1, OFF_ROUTE_A, 32'h0000_4444);
    byteenable <= 4'hF;
    bus(1'b0, OFF_ROUTE_A, 32'h0000_0000);
    chk("byte lanes", 32'h0000_4433, rd);
  endtask

  task t_rereset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("out_circuit in reset", 32'h0000_0000, 32'(out_circuit));
    @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, OFF_POLARITY_A, 32'h0000_0000);
    chk("polarity after reset", 32'h0000_0000, rd);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1 chk("out_circuit in reset", 32'h0000_0000, 32'(out_circuit));
    @(posedge ref_clk);
    rst <= 1'b0;
    func_level <= 16'h0000;
    t_reset_values();
    t_place();
    t_single();
    t_or_and_valid();
    t_polarity();
    t_refused();
    t_rereset();
    report_and_stop;
  end
endmodule // output_signal_allocator_tb_top
